// File: hw/ssr_pkg.sv
package ssr_pkg;

  // serial opcode for a status read
  localparam logic [7:0] OPC_READ_STATUS = 8'h05;
  localparam int OPC_BITS = 8;

  // bits in one pass of byte one then byte two
  localparam int PASS_BITS = 16;

  // number of sector protection registers held in the block
  localparam int SECTORS = 4;

  // status byte one field positions
  localparam int B1_LOCK = 7;
  localparam int B1_SEQ = 6;
  localparam int B1_ERR = 5;
  localparam int B1_WPP = 4;
  localparam int B1_SWP_HI = 3;
  localparam int B1_SWP_LO = 2;
  localparam int B1_WEL = 1;
  localparam int B1_BUSY = 0;

  // status byte two field positions
  localparam int B2_RESET_COMMAND_ENABLE = 4;
  localparam int B2_BUSY = 0;

  // software protection summary codes
  localparam logic [1:0] SWP_NONE = 2'h0;
  localparam logic [1:0] SWP_SOME = 2'h1;
  localparam logic [1:0] SWP_ALL = 2'h3;

  // values after reset
  localparam logic RST_LOCK = 1'h0;
  localparam logic RST_ERR = 1'h0;
  localparam logic RST_RESET_COMMAND_ENABLE = 1'h0;
  localparam logic [SECTORS-1:0] RST_SECT = {SECTORS{1'b1}};

  // serial engine states, gray along idle -> opcode -> stream
  typedef enum logic [1:0] {
    SSR_IDLE = 2'h0,
    SSR_OPCODE = 2'h1,
    SSR_STREAM = 2'h3,
    SSR_IGNORE = 2'h2
  } ssr_state_t;

endpackage

// File: hw/ssr_sync2.sv
// two-flop synchroniser for levels arriving from another domain
module ssr_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // meta_r feeds only q; clears to zero, so the caller inverts select, but not wp_n
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// File: hw/ssr_status.sv
module ssr_status (
  input wire logic clk,
  input wire logic reset,
  // serial link pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe_n,
  // write-protect pin, low = asserted
  input wire logic wp_n,
  // state from the program/erase engine, same clock
  input wire logic seq_mode,
  input wire logic write_enable_latch_flag,
  input wire logic busy,
  input wire logic op_end_stb,
  input wire logic op_fail,
  input wire logic op_aborted,
  // decoded commands, same clock
  input wire logic wr_status_stb,
  input wire logic [7:0] wr_status_data,
  input wire logic wr_status2_stb,
  input wire logic [7:0] wr_status2_data,
  input wire logic sect_cmd_stb,
  input wire logic sect_cmd_protect,
  input wire logic [1:0] sect_cmd_idx,
  input wire logic global_stb,
  input wire logic global_protect,
  // observed state
  output logic [7:0] status_byte_one_r,
  output logic [7:0] status_byte_two_r,
  output logic [ssr_pkg::SECTORS-1:0] sector_prot_r,
  output logic reset_cmd_en_r,
  output logic sect_refused_r
);

  logic [3:0] pins_s;
  logic sck_s;
  logic cs_n_s;
  logic si_s;
  logic wp_n_s;
  logic sck_d_r;
  logic sck_rise;
  logic sck_fall;

  ssr_pkg::ssr_state_t state_r;
  ssr_pkg::ssr_state_t state_nxt;

  logic [7:0] opc_r;
  logic [2:0] opc_cnt_r;
  logic [3:0] bit_idx_r;
  logic pass_head;
  logic [15:0] shift_r;
  logic so_r;
  logic so_oe_n_r;

  logic lock_r;
  logic err_r;
  logic reset_command_enable_r;
  logic [ssr_pkg::SECTORS-1:0] sect_r;
  logic refused_r;
  logic [7:0] byte1_r;
  logic [7:0] byte2_r;
  logic [7:0] byte1_now;
  logic [7:0] byte2_now;
  logic [7:0] opc_full;

  // summary of the sector protection registers
  function automatic logic [1:0] swp_of(
    input logic [ssr_pkg::SECTORS-1:0] v
  );
    logic [1:0] r;
    r = ssr_pkg::SWP_SOME;
    if (v == '0) begin
      r = ssr_pkg::SWP_NONE;
    end else if (&v) begin
      r = ssr_pkg::SWP_ALL;
    end
    return r;
  endfunction

  // pins cross from the link domain before anything looks at them
  // select goes in inverted so the cleared synchroniser reads deselected
  ssr_sync2 #(
    .W(4)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .d({sck, ~cs_n, si, wp_n}),
    .q(pins_s)
  );

  assign sck_s = pins_s[3];
  assign cs_n_s = ~pins_s[2];
  assign si_s = pins_s[1];
  assign wp_n_s = pins_s[0];

  // cleared to the mode 0 idle level; a mode 3 idle clock after reset
  // is masked by select, which reads deselected until the sync fills
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sck_d_r <= 1'b0;
    end else begin
      sck_d_r <= sck_s;
    end
  end

  // gated by select so idle clock toggling does nothing
  assign sck_rise = sck_s & ~sck_d_r & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_d_r & ~cs_n_s;

  // live status words
  always_comb begin
    byte1_now = 8'h00;
    byte1_now[ssr_pkg::B1_LOCK] = lock_r;
    byte1_now[ssr_pkg::B1_SEQ] = seq_mode;
    byte1_now[ssr_pkg::B1_ERR] = err_r;
    byte1_now[ssr_pkg::B1_WPP] = wp_n_s;
    byte1_now[ssr_pkg::B1_SWP_HI:ssr_pkg::B1_SWP_LO] =
      swp_of(sect_r);
    byte1_now[ssr_pkg::B1_WEL] = write_enable_latch_flag;
    byte1_now[ssr_pkg::B1_BUSY] = busy;
  end

  always_comb begin
    byte2_now = 8'h00;
    byte2_now[ssr_pkg::B2_RESET_COMMAND_ENABLE] = reset_command_enable_r;
    // busy copy lets a host poll from either byte
    byte2_now[ssr_pkg::B2_BUSY] = busy;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      byte1_r <= 8'h00;
      byte2_r <= 8'h00;
    end else begin
      byte1_r <= byte1_now;
      byte2_r <= byte2_now;
    end
  end

  assign opc_full = {opc_r[6:0], si_s};

  // serial engine; busy never holds it off
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ssr_pkg::SSR_IDLE: begin
        if (!cs_n_s) begin
          state_nxt = ssr_pkg::SSR_OPCODE;
        end
      end
      ssr_pkg::SSR_OPCODE: begin
        if (cs_n_s) begin
          state_nxt = ssr_pkg::SSR_IDLE;
        end else if (sck_rise && opc_cnt_r == 3'(ssr_pkg::OPC_BITS - 1)) begin
          if (opc_full == ssr_pkg::OPC_READ_STATUS) begin
            state_nxt = ssr_pkg::SSR_STREAM;
          end else begin
            state_nxt = ssr_pkg::SSR_IGNORE;
          end
        end
      end
      ssr_pkg::SSR_STREAM: begin
        if (cs_n_s) begin
          state_nxt = ssr_pkg::SSR_IDLE;
        end
      end
      ssr_pkg::SSR_IGNORE: begin
        if (cs_n_s) begin
          state_nxt = ssr_pkg::SSR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= ssr_pkg::SSR_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // opcode capture on rising clock
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      opc_r <= 8'h00;
      opc_cnt_r <= 3'h0;
    end else if (state_r != ssr_pkg::SSR_OPCODE) begin
      opc_r <= 8'h00;
      opc_cnt_r <= 3'h0;
    end else if (sck_rise) begin
      opc_r <= opc_full;
      opc_cnt_r <= opc_cnt_r + 3'h1;
    end
  end

  // position in the pass; wraps back to byte one bit 7
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bit_idx_r <= 4'h0;
    end else if (state_r != ssr_pkg::SSR_STREAM) begin
      bit_idx_r <= 4'h0;
    end else if (sck_fall) begin
      if (bit_idx_r == 4'(ssr_pkg::PASS_BITS - 1)) begin
        bit_idx_r <= 4'h0;
      end else begin
        bit_idx_r <= bit_idx_r + 4'h1;
      end
    end
  end

  assign pass_head = (bit_idx_r == 4'h0);

  // fresh snapshot at the head of every pass
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_r <= 16'h0000;
    end else if (state_r != ssr_pkg::SSR_STREAM) begin
      shift_r <= 16'h0000;
    end else if (sck_fall && pass_head) begin
      shift_r <= {byte1_now[6:0], byte2_now, 1'b0};
    end else if (sck_fall) begin
      shift_r <= {shift_r[14:0], 1'b0};
    end
  end

  // one status bit per falling edge after the opcode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      so_r <= 1'b0;
    end else if (state_r != ssr_pkg::SSR_STREAM) begin
      so_r <= 1'b0;
    end else if (sck_fall) begin
      so_r <= pass_head ? byte1_now[7] : shift_r[15];
    end
  end

  // output drives only once the first bit is placed
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      so_oe_n_r <= 1'b1;
    end else if (state_nxt != ssr_pkg::SSR_STREAM) begin
      so_oe_n_r <= 1'b1;
    end else if (sck_fall) begin
      so_oe_n_r <= 1'b0;
    end
  end

  // protection lock; write-status touches nothing else
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_r <= ssr_pkg::RST_LOCK;
    end else if (wr_status_stb) begin
      // pin reads asserted while the sync fills: a clear is refused then
      if (wp_n_s) begin
        lock_r <= wr_status_data[ssr_pkg::B1_LOCK];
      end else if (wr_status_data[ssr_pkg::B1_LOCK]) begin
        lock_r <= 1'b1;
      end
    end
  end

  // byte two write changes only the reset enable
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reset_command_enable_r <= ssr_pkg::RST_RESET_COMMAND_ENABLE;
    end else if (wr_status2_stb) begin
      reset_command_enable_r <= wr_status2_data[ssr_pkg::B2_RESET_COMMAND_ENABLE];
    end
  end

  // error flag follows only the latest finished operation
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      err_r <= ssr_pkg::RST_ERR;
    end else if (op_end_stb) begin
      if (op_aborted) begin
        err_r <= 1'b0;
      end else begin
        err_r <= op_fail;
      end
    end
  end

  // sector protection registers, frozen while locked
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sect_r <= ssr_pkg::RST_SECT;
    end else if (!lock_r) begin
      // global wins over a single-sector strobe in the same cycle
      if (global_stb) begin
        sect_r <= {ssr_pkg::SECTORS{global_protect}};
      end else if (sect_cmd_stb) begin
        sect_r[sect_cmd_idx] <= sect_cmd_protect;
      end
    end
  end

  // refusal pulse when a sector or global command meets the lock
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      refused_r <= 1'b0;
    end else begin
      refused_r <= lock_r & (global_stb | sect_cmd_stb);
    end
  end

  assign so = so_r;
  assign so_oe_n = so_oe_n_r;
  assign status_byte_one_r = byte1_r;
  assign status_byte_two_r = byte2_r;
  assign sector_prot_r = sect_r;
  assign reset_cmd_en_r = reset_command_enable_r;
  assign sect_refused_r = refused_r;

endmodule

// File: sim/ssr_status_assertions.sv
module ssr_status_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic so,
  input wire logic so_oe_n,
  input wire logic busy,
  input wire logic write_enable_latch_flag,
  input wire logic op_end_stb,
  input wire logic op_fail,
  input wire logic op_aborted,
  input wire logic wr_status_stb,
  input wire logic [7:0] wr_status_data,
  input wire logic sect_cmd_stb,
  input wire logic [7:0] status_byte_one_r,
  input wire logic [7:0] status_byte_two_r,
  input wire logic [ssr_pkg::SECTORS-1:0] sector_prot_r,
  input wire logic sect_refused_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire [7:0] s1 = status_byte_one_r;
  wire [7:0] b2 = status_byte_two_r;
  wire [3:0] sp = sector_prot_r;
  property p_lock; wr_status_stb && wr_status_data[7] |-> ##2 s1[7];
  endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_live; !$past(reset) |-> s1[0] == $past(busy) &&
    s1[1] == $past(write_enable_latch_flag); endproperty
  a_live: assert property (p_live) else $error("live");
  property p_b2; b2[7:5] == 3'h0 && b2[3:1] == 3'h0 && b2[0] == s1[0];
  endproperty
  a_b2: assert property (p_b2) else $error("byte two");
  // lock lags one cycle in s1, so skip a write just before
  property p_ref; sect_cmd_stb && s1[7] && !$past(wr_status_stb) |=>
    sect_refused_r && $stable(sector_prot_r); endproperty
  a_ref: assert property (p_ref) else $error("refuse");
  property p_swp; !$past(reset) |-> s1[3:2] == (&$past(sp) ? 2'h3 :
    |$past(sp) ? 2'h1 : 2'h0); endproperty
  a_swp: assert property (p_swp) else $error("summary");
  property p_eset; op_end_stb && op_fail && !op_aborted |-> ##2 s1[5];
  endproperty
  a_eset: assert property (p_eset) else $error("err set");
  property p_eclr; op_end_stb && !(op_fail && !op_aborted) |-> ##2 !s1[5];
  endproperty
  a_eclr: assert property (p_eclr) else $error("eclr");
  property p_tri; cs_n [*8] |-> so_oe_n; endproperty
  a_tri: assert property (p_tri) else $error("float");
  property p_hold; $changed(so) |-> !sck && !$past(sck); endproperty
  a_hold: assert property (p_hold) else $error("edge");
  c_read: cover property (!so_oe_n);
  c_ref: cover property (sect_refused_r);
  c_err: cover property (s1[5]);
endmodule

bind ssr_status ssr_status_assertions u_chk (
  .clk, .reset, .sck, .cs_n, .so, .so_oe_n, .busy, .write_enable_latch_flag, .op_end_stb,
  .op_fail, .op_aborted, .wr_status_stb, .wr_status_data, .sect_cmd_stb,
  .status_byte_one_r, .status_byte_two_r, .sector_prot_r, .sect_refused_r);

// File: sim/ssr_host.sv
module ssr_host (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sck = 1'h0;
    cs_n = 1'h1;
    si = 1'h0;
  end
  // odd start keeps sck edges off the system clock edges
  task automatic run(input logic [7:0] opc, input int n,
                     output logic [31:0] d, output logic [31:0] oe);
    d = '0;
    oe = '0;
    #1 cs_n = 1'h0;
    for (int i = 0; i < 8 + n; i++) begin
      si = i < 8 ? opc[7 - i] : ~si;
      #80 sck = 1'h1;
      if (i >= 8) begin
        d = {d[30:0], so};
        oe = {oe[30:0], so_oe_n};
      end
      #80 sck = 1'h0;
    end
    // release may fall mid-byte
    #40 cs_n = 1'h1;
    #40;
  endtask
endmodule

// File: sim/ssr_status_test.sv
module ssr_status_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = '0, reset = '1, wp_n = '1, seq_mode = '0, write_enable_latch_flag = '0, busy = '0;
  logic op_end_stb = '0, op_fail = '0, op_aborted = '0, global_stb = '0;
  logic wr_status_stb = '0, wr_status2_stb = '0, sect_cmd_stb = '0;
  logic sect_cmd_protect = '0, global_protect = '0;
  logic [7:0] wr_status_data = '0, wr_status2_data = '0;
  logic [1:0] sect_cmd_idx = '0;
  logic sck, cs_n, si, so, so_oe_n, reset_cmd_en_r, sect_refused_r;
  logic [7:0] status_byte_one_r, status_byte_two_r;
  logic [ssr_pkg::SECTORS-1:0] sector_prot_r;
  logic [31:0] d, oe;
  logic ref_seen;
  int mismatches = 0, n_tests = 0;
  always #2 clk = ~clk;
  ssr_status u_ssr_status (.clk, .reset, .sck, .cs_n, .si, .so, .so_oe_n,
    .wp_n, .seq_mode, .write_enable_latch_flag, .busy, .op_end_stb, .op_fail, .op_aborted,
    .wr_status_stb, .wr_status_data, .wr_status2_stb, .wr_status2_data,
    .sect_cmd_stb, .sect_cmd_protect, .sect_cmd_idx, .global_stb,
    .global_protect, .status_byte_one_r, .status_byte_two_r,
    .sector_prot_r, .reset_cmd_en_r, .sect_refused_r);
  ssr_host u_ssr_host (.sck, .cs_n, .si, .so, .so_oe_n);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d checks %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // 0 wr1, 1 wr2, 2 sector {prot,idx}, 3 global, 4 op end {fail,abort}
  task automatic cmd(input int k, input logic [7:0] v);
    @(negedge clk);
    case (k)
      0: {wr_status_stb, wr_status_data} = {1'h1, v};
      1: {wr_status2_stb, wr_status2_data} = {1'h1, v};
      2: {sect_cmd_stb, sect_cmd_protect, sect_cmd_idx} = {1'h1, v[2:0]};
      3: {global_stb, global_protect} = {1'h1, v[0]};
      default: {op_end_stb, op_fail, op_aborted} = {1'h1, v[1:0]};
    endcase
    @(negedge clk);
    ref_seen = sect_refused_r;
    {wr_status_stb, wr_status2_stb, sect_cmd_stb, global_stb} = '0;
    op_end_stb = 1'h0;
    tick(2);
  endtask
  task automatic t_read();
    u_ssr_host.run(8'h05, 16, d, oe);
    check(d, 32'h1C00);
    check(oe, 32'h0);
    tick(1);
    {seq_mode, write_enable_latch_flag, busy} = 3'h7;
    fork
      u_ssr_host.run(8'h05, 32, d, oe);
      begin
        #2000;
        @(negedge clk);
        busy = 1'h0;
      end
    join
    check(d, 32'h5F015E00);
    tick(1);
    {seq_mode, write_enable_latch_flag} = 2'h0;
  endtask
  task automatic t_abort();
    u_ssr_host.run(8'h05, 4, d, oe);
    check(d, 32'h1);
    check(32'(so_oe_n), 32'h1);
    tick(1);
    u_ssr_host.run(8'h06, 8, d, oe);
    check(oe, 32'hFF);
    tick(1);
    wp_n = 1'h0;
    u_ssr_host.run(8'h05, 8, d, oe);
    check(d, 32'h0C);
  endtask
  task automatic t_lock();
    cmd(0, 8'hFF);
    check(32'(status_byte_one_r), 32'h8C);
    cmd(2, 8'h00);
    check(32'(ref_seen), 32'h1);
    cmd(3, 8'h00);
    check(32'(ref_seen), 32'h1);
    check(32'(sector_prot_r), 32'hF);
    cmd(0, 8'h00);
    check(32'(status_byte_one_r), 32'h8C);
    wp_n = 1'h1;
    tick(4);
    cmd(0, 8'h00);
    check(32'(status_byte_one_r), 32'h1C);
    cmd(2, 8'h01);
    check(32'(ref_seen), 32'h0);
    check(32'(status_byte_one_r), 32'h14);
    cmd(3, 8'h00);
    check(32'(status_byte_one_r), 32'h10);
    cmd(3, 8'h01);
    check(32'(sector_prot_r), 32'hF);
  endtask
  task automatic t_err();
    logic [7:0] opv;
    opv = 8'hB8;
    for (int i = 0; i < 4; i++) begin
      cmd(4, {6'h0, opv[7-2*i -: 2]});
      check(32'(status_byte_one_r[5]), 32'(!i[0]));
    end
    cmd(4, 8'h02);
    check(32'(status_byte_one_r[5]), 32'h1);
    cmd(4, 8'h03);
    check(32'(status_byte_one_r[5]), 32'h0);
  endtask
  task automatic t_b2();
    cmd(1, 8'hFF);
    check(32'(status_byte_two_r), 32'h10);
    check(32'(reset_cmd_en_r), 32'h1);
  endtask
  initial begin
    tick(5);
    reset = 1'h0;
    tick(6);
    t_read();
    t_abort();
    t_lock();
    t_err();
    t_b2();
    finish_test();
  end
  initial begin
    #60000;
    mismatches++;
    finish_test();
  end
endmodule
